// ### rtl/core_clock_select_and_sixteen_bit_timer.sv
// Core clock selection, oscillator enables and the 16-bit timer.
// Assumes oscillators and port pins are asynchronous levels, sampled on clk_sys.
// Functional notes
// - Slow-RC calibration option leaves clock mode 0xE4 after boot.
// - Calibration disabled: clock mode keeps its 0xE6 default with the boot strap set, else boots to 0xD6.
// - Crystal control bit 7 enables the crystal oscillator.
// - Crystal control bits 6:5 choose low, medium or high drive.
// - Crystal supported only from 32 kHz to 4 MHz.
// - Core clock comes from exactly one of fast RC, slow RC, crystal.
// - A clock mode write switches source and divider at once.
// - 0x34 fast/2, 0x14 fast/4, 0xF4 slow, 0xB0 crystal.
// - Crystal, fast RC and slow RC enables are independent bits.
// - Timer clock: core, fast RC, slow RC, crystal, line0 or line4.
// - Prescaler divides by 1, 4, 16 or 64 from timer mode bits 4:3.
// - Counter counts up by one per prescaled tick and wraps.
// - Store strobe loads counter; load strobe returns current count.
// - Timer mode bits 2:0 pick counter bit 8 to 15.
// - Edge select bit 4 picks rising or falling transition.
// - Timer mode bits 7:5 pick the clock source, zero stops.
// - Request flag bit 2 sets on each qualifying edge.
`timescale 1ns/1ns
module core_clock_select_and_sixteen_bit_timer (
	input  wire logic        clk_sys,
	input  wire logic        resetn,
	input  wire logic [5:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_write,
	input  wire logic        reg_read,
	output logic [7:0]       reg_rdata,
	input  wire logic        counter_store_insn,
	input  wire logic [15:0] counter_store_data,
	input  wire logic        counter_load_insn,
	output logic [15:0]      counter_load_data,
	input  wire logic        internal_fast_rc,
	input  wire logic        internal_slow_rc,
	input  wire logic        crystal_oscillator,
	input  wire logic        port_a_line0,
	input  wire logic        port_a_line4,
	input  wire logic [1:0]  calibration_directive,
	input  wire logic        boot_fast_strap,
	output logic             fast_rc_enable,
	output logic             slow_rc_enable,
	output logic             crystal_enable,
	output logic [1:0]       crystal_drive,
	output logic [1:0]       core_clock_source,
	output logic [2:0]       core_clock_div_log2,
	output logic             watchdog_enable,
	output logic             port_a_line5_input,
	output logic             timer_request
);

	////////////////////////////////////////////////////////////////////////////////////////
	// Decoding functions

	// Source from clock mode bits 7:5
	function automatic clk_timer_pkg::core_src_type mode_source(input logic [7:0] mode);
		clk_timer_pkg::core_src_type src;
		src = clk_timer_pkg::SRC_FAST;
		if (mode[7:5] == 3'b111)
			src = clk_timer_pkg::SRC_SLOW;
		else if (mode[7:5] == 3'b101)
			src = clk_timer_pkg::SRC_XTAL;
		return src;
	endfunction : mode_source

	// Divider as a power of two; unlisted fast codes run at /64
	function automatic logic [2:0] mode_div_log2(input logic [7:0] mode);
		logic [2:0] lg;
		lg = 3'h6;
		case ({mode[7:5], mode[3]})
			4'b0010: lg = 3'h1;
			4'b0000: lg = 3'h2;
			4'b0011: lg = 3'h3;
			4'b0001: lg = 3'h4;
			4'b0111: lg = 3'h5;
			4'b1110, 4'b1111, 4'b1010, 4'b1011: lg = 3'h0;
			default: lg = 3'h6;
		endcase
		return lg;
	endfunction : mode_div_log2

	// All-ones mask of a given width, used by both dividers
	function automatic logic [5:0] low_mask(input logic [2:0] lg);
		return 6'(({1'b0, 6'h3f} >> (3'h6 - lg)) & 7'h3f);
	endfunction : low_mask

	////////////////////////////////////////////////////////////////////////////////////////
	// Pin and oscillator edge sampling

	wire  [clk_timer_pkg::PIN_COUNT-1:0] pin_vec = {port_a_line4, port_a_line0,
		crystal_oscillator, internal_slow_rc, internal_fast_rc};
	logic [clk_timer_pkg::PIN_COUNT-1:0] pin_rise;

	genvar gi;
	generate
		for (gi = 0; gi < clk_timer_pkg::PIN_COUNT; gi++) begin : g_pin
			pin_edge_sync u_sync (
				.clk_sys (clk_sys),
				.resetn  (resetn),
				.pin     (pin_vec[gi]),
				.rise_q  (pin_rise[gi])
			);
		end
	endgenerate

	// Straps pass two flops before the boot logic reads them
	logic [2:0] strap_meta_q;
	logic [2:0] strap_sync_q;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			strap_meta_q <= 3'h0;
			strap_sync_q <= 3'h0;
		end else begin
			strap_meta_q <= {boot_fast_strap, calibration_directive};
			strap_sync_q <= strap_meta_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////
	// Registers and boot sequence

	clk_timer_pkg::boot_state_type boot_q;
	clk_timer_pkg::boot_state_type boot_d;
	logic [7:0] clock_mode_q;
	logic [7:0] clock_mode_d;
	logic [7:0] sixteen_bit_timer_mode_q;
	logic [7:0] crystal_ctrl_q;
	logic [7:0] edge_select_q;
	logic       t16_flag_q;
	logic       t16_flag_d;
	logic       t16_event;

	always_comb begin
		case (boot_q)
			clk_timer_pkg::BOOT_WAIT1: boot_d = clk_timer_pkg::BOOT_WAIT2;
			clk_timer_pkg::BOOT_WAIT2: boot_d = clk_timer_pkg::BOOT_APPLY;
			clk_timer_pkg::BOOT_APPLY: boot_d = clk_timer_pkg::BOOT_RUN;
			clk_timer_pkg::BOOT_RUN:   boot_d = clk_timer_pkg::BOOT_RUN;
			default:                   boot_d = clk_timer_pkg::BOOT_RUN;
		endcase
	end

	wire boot_apply = (boot_q == clk_timer_pkg::BOOT_APPLY);
	wire booted     = (boot_q == clk_timer_pkg::BOOT_RUN);
	wire wr_mode    = booted & reg_write & (reg_addr == clk_timer_pkg::CLOCK_MODE_OFFSET);
	wire wr_t16     = reg_write & (reg_addr == clk_timer_pkg::SIXTEEN_BIT_TIMER_MODE_OFFSET);
	wire wr_xtal    = reg_write & (reg_addr == clk_timer_pkg::CRYSTAL_CTRL_OFFSET);
	wire wr_edge    = reg_write & (reg_addr == clk_timer_pkg::EDGE_SELECT_OFFSET);
	wire wr_flags   = reg_write & (reg_addr == clk_timer_pkg::IRQ_FLAGS_OFFSET);

	// Boot value by calibration option; disabled keeps the default only with the fast strap set, else loads 0xD6
	wire [1:0] cal_opt = strap_sync_q[1:0];
	wire [7:0] boot_mode =
		(cal_opt == clk_timer_pkg::CAL_SLOW)  ? clk_timer_pkg::CLOCK_MODE_SLOW_CAL :
		(cal_opt == clk_timer_pkg::CAL_FAST2) ? clk_timer_pkg::CLOCK_MODE_FAST2_CAL :
		(cal_opt == clk_timer_pkg::CAL_FAST4) ? clk_timer_pkg::CLOCK_MODE_FAST4_CAL :
		strap_sync_q[2] ? clk_timer_pkg::CLOCK_MODE_RESET :
		clk_timer_pkg::CLOCK_MODE_BOOT_FAST64;

	assign clock_mode_d = boot_apply ? boot_mode :
		wr_mode ? reg_wdata : clock_mode_q;

	// Hardware set wins over a clearing write
	assign t16_flag_d = t16_event |
		(wr_flags ? reg_wdata[clk_timer_pkg::FLAG_T16_BIT] : t16_flag_q);

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			boot_q         <= clk_timer_pkg::BOOT_WAIT1;
			clock_mode_q   <= clk_timer_pkg::CLOCK_MODE_RESET;
			sixteen_bit_timer_mode_q <= clk_timer_pkg::REG_RESET;
			crystal_ctrl_q <= clk_timer_pkg::REG_RESET;
			edge_select_q  <= clk_timer_pkg::REG_RESET;
			t16_flag_q     <= 1'b0;
		end else begin
			boot_q       <= boot_d;
			clock_mode_q <= clock_mode_d;
			t16_flag_q   <= t16_flag_d;
			if (wr_t16)
				sixteen_bit_timer_mode_q <= reg_wdata;
			if (wr_xtal)
				crystal_ctrl_q <= reg_wdata;
			if (wr_edge)
				edge_select_q <= reg_wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////
	// Register read port

	wire [7:0] read_value =
		(reg_addr == clk_timer_pkg::CLOCK_MODE_OFFSET)   ? clock_mode_q :
		(reg_addr == clk_timer_pkg::SIXTEEN_BIT_TIMER_MODE_OFFSET) ? sixteen_bit_timer_mode_q :
		(reg_addr == clk_timer_pkg::CRYSTAL_CTRL_OFFSET) ? crystal_ctrl_q :
		(reg_addr == clk_timer_pkg::EDGE_SELECT_OFFSET)  ? edge_select_q :
		(reg_addr == clk_timer_pkg::IRQ_FLAGS_OFFSET)    ?
			(8'h01 << clk_timer_pkg::FLAG_T16_BIT) & {8{t16_flag_q}} : 8'h00;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn)
			reg_rdata <= 8'h00;
		else
			reg_rdata <= reg_read ? read_value : 8'h00;
	end

	////////////////////////////////////////////////////////////////////////////////////////
	// Oscillator enables and core clock selection

	wire        fast_on_d = clock_mode_d[clk_timer_pkg::FAST_EN_BIT];
	wire        slow_on_d = clock_mode_d[clk_timer_pkg::SLOW_EN_BIT];
	wire [1:0]  source_d  = mode_source(clock_mode_d);
	wire [2:0]  div_d     = mode_div_log2(clock_mode_d);

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			fast_rc_enable      <= clk_timer_pkg::CLOCK_MODE_RESET[clk_timer_pkg::FAST_EN_BIT];
			slow_rc_enable      <= clk_timer_pkg::CLOCK_MODE_RESET[clk_timer_pkg::SLOW_EN_BIT];
			crystal_enable      <= 1'b0;
			crystal_drive       <= 2'b00;
			core_clock_source   <= clk_timer_pkg::SRC_SLOW;
			core_clock_div_log2 <= 3'h0;
			watchdog_enable     <= clk_timer_pkg::CLOCK_MODE_RESET[clk_timer_pkg::WDOG_EN_BIT];
			port_a_line5_input  <= 1'b1;
		end else begin
			fast_rc_enable      <= fast_on_d;
			slow_rc_enable      <= slow_on_d;
			crystal_enable      <= crystal_ctrl_q[clk_timer_pkg::XTAL_EN_BIT];
			crystal_drive       <= crystal_ctrl_q[clk_timer_pkg::XTAL_DRV_HI:
				clk_timer_pkg::XTAL_DRV_LO];
			core_clock_source   <= source_d;
			core_clock_div_log2 <= div_d;
			watchdog_enable     <= clock_mode_d[clk_timer_pkg::WDOG_EN_BIT];
			port_a_line5_input  <= ~clock_mode_d[clk_timer_pkg::PA5_MODE_BIT];
		end
	end

	// An oscillator only ticks while enabled; crystal edges up to 4 MHz sample cleanly
	wire fast_tick = pin_rise[clk_timer_pkg::PIN_FAST] & fast_rc_enable;
	wire slow_tick = pin_rise[clk_timer_pkg::PIN_SLOW] & slow_rc_enable;
	wire xtal_tick = pin_rise[clk_timer_pkg::PIN_XTAL] & crystal_enable;

	wire src_tick =
		(core_clock_source == clk_timer_pkg::SRC_SLOW) ? slow_tick :
		(core_clock_source == clk_timer_pkg::SRC_XTAL) ? xtal_tick : fast_tick;

	logic [5:0] core_div_q;
	wire        core_div_end = (core_div_q & low_mask(core_clock_div_log2)) ==
		low_mask(core_clock_div_log2);
	wire        core_tick    = src_tick & core_div_end;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn)
			core_div_q <= 6'h00;
		else if (wr_mode)
			core_div_q <= 6'h00;
		else if (src_tick)
			core_div_q <= core_div_end ? 6'h00 : core_div_q + 6'h01;
	end

	////////////////////////////////////////////////////////////////////////////////////////
	// Timer source, prescaler and counter

	wire [2:0] t16_src = sixteen_bit_timer_mode_q[clk_timer_pkg::T16_SRC_HI:clk_timer_pkg::T16_SRC_LO];
	wire [1:0] t16_pre = sixteen_bit_timer_mode_q[clk_timer_pkg::T16_PRE_HI:clk_timer_pkg::T16_PRE_LO];
	wire [2:0] t16_bit = sixteen_bit_timer_mode_q[clk_timer_pkg::T16_BIT_HI:clk_timer_pkg::T16_BIT_LO];

	logic t16_src_tick;
	always_comb begin
		case (t16_src)
			clk_timer_pkg::T16_CORE: t16_src_tick = core_tick;
			clk_timer_pkg::T16_PA4:  t16_src_tick = pin_rise[clk_timer_pkg::PIN_PA4];
			clk_timer_pkg::T16_FAST: t16_src_tick = fast_tick;
			clk_timer_pkg::T16_XTAL: t16_src_tick = xtal_tick;
			clk_timer_pkg::T16_SLOW: t16_src_tick = slow_tick;
			clk_timer_pkg::T16_PA0:  t16_src_tick = pin_rise[clk_timer_pkg::PIN_PA0];
			default:                 t16_src_tick = 1'b0;
		endcase
	end

	logic [5:0]  pre_q;
	logic [15:0] count_q;
	wire  [5:0]  pre_mask  = low_mask({t16_pre, 1'b0});
	wire         pre_end   = (pre_q & pre_mask) == pre_mask;
	wire         count_inc = t16_src_tick & pre_end;
	wire  [15:0] count_nxt = count_q + 16'h0001;
	wire  [3:0]  sel_idx   = {1'b1, t16_bit};
	wire         sel_old   = count_q[sel_idx];
	wire         sel_new   = count_nxt[sel_idx];
	wire         falling   = edge_select_q[clk_timer_pkg::EDGE_T16_BIT];

	assign t16_event = count_inc & ~counter_store_insn &
		(falling ? (sel_old & ~sel_new) : (~sel_old & sel_new));

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn)
			pre_q <= 6'h00;
		else if (t16_src_tick)
			pre_q <= pre_end ? 6'h00 : pre_q + 6'h01;
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn)
			count_q <= 16'h0000;
		else if (counter_store_insn)
			count_q <= counter_store_data;
		else if (count_inc)
			count_q <= count_nxt;
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			counter_load_data <= 16'h0000;
			timer_request     <= 1'b0;
		end else begin
			counter_load_data <= counter_load_insn ? count_q : counter_load_data;
			timer_request     <= t16_flag_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	boot_slow_mode_a: assert property (
		boot_apply && cal_opt == clk_timer_pkg::CAL_SLOW |=> clock_mode_q == 8'he4)
		else $error("slow calibration boot value wrong");
	boot_untouched_a: assert property (
		boot_apply && cal_opt == clk_timer_pkg::CAL_DISABLED && strap_sync_q[2]
		|=> clock_mode_q == $past(clock_mode_q))
		else $error("disabled calibration changed clock mode");
	crystal_enable_a: assert property (
		wr_xtal |=> ##1 crystal_enable == $past(reg_wdata[7], 2))
		else $error("crystal enable not following control bit");
	crystal_drive_a: assert property (
		wr_xtal |=> ##1 crystal_drive == $past(reg_wdata[6:5], 2))
		else $error("crystal drive not following control bits");
	switch_now_a: assert property (
		wr_mode && reg_wdata == 8'hb0 |=> core_clock_source == clk_timer_pkg::SRC_XTAL)
		else $error("crystal select not immediate");
	switch_div_a: assert property (
		wr_mode && reg_wdata == 8'h14 |=> core_clock_div_log2 == 3'h2 &&
		core_clock_source == clk_timer_pkg::SRC_FAST && fast_rc_enable && slow_rc_enable)
		else $error("fast RC divide by four decode wrong");
	one_source_a: assert property (
		clock_mode_q == 8'hf4 || clock_mode_q == 8'he4 |->
		core_clock_source == clk_timer_pkg::SRC_SLOW)
		else $error("slow RC mode not clocking from slow RC");
	stop_count_a: assert property (
		t16_src == clk_timer_pkg::T16_STOP && !counter_store_insn |=> $stable(count_q))
		else $error("stopped timer moved");
	count_step_a: assert property (
		count_inc && !counter_store_insn |=> count_q == $past(count_q) + 16'h0001)
		else $error("counter step wrong");
	store_load_a: assert property (
		counter_store_insn ##1 counter_load_insn |=>
		counter_load_data == $past(counter_store_data, 2))
		else $error("loaded count does not match");
	flag_set_a: assert property (
		t16_event |=> t16_flag_q && timer_request)
		else $error("timer event lost");
	presc_gate_a: assert property (
		t16_pre == 2'b01 && count_inc |-> (pre_q[1:0] == 2'b11))
		else $error("prescaler passed early");

	switch_crystal_c: cover property (wr_mode && reg_wdata == 8'hb0);
	flag_event_c:     cover property (t16_event ##1 wr_flags);
	count_wrap_c:     cover property (count_inc && count_q == 16'hffff);

endmodule : core_clock_select_and_sixteen_bit_timer

// ### pkg/clk_timer_pkg.sv
// Constants for the clock-control and 16-bit timer block.
// Assumes one system clock; oscillators and port pins arrive as sampled inputs.
package clk_timer_pkg;

	// Register offsets on the plain register port
	localparam logic [5:0] CLOCK_MODE_OFFSET  = 6'h03;
	localparam logic [5:0] IRQ_FLAGS_OFFSET   = 6'h05;
	localparam logic [5:0] SIXTEEN_BIT_TIMER_MODE_OFFSET = 6'h06;
	localparam logic [5:0] CRYSTAL_CTRL_OFFSET = 6'h0a;
	localparam logic [5:0] EDGE_SELECT_OFFSET = 6'h0c;

	// Field positions
	localparam int XTAL_EN_BIT   = 7;
	localparam int XTAL_DRV_HI   = 6;
	localparam int XTAL_DRV_LO   = 5;
	localparam int FAST_EN_BIT   = 4;
	localparam int SLOW_EN_BIT   = 2;
	localparam int WDOG_EN_BIT   = 1;
	localparam int PA5_MODE_BIT  = 0;
	localparam int T16_SRC_HI    = 7;
	localparam int T16_SRC_LO    = 5;
	localparam int T16_PRE_HI    = 4;
	localparam int T16_PRE_LO    = 3;
	localparam int T16_BIT_HI    = 2;
	localparam int T16_BIT_LO    = 0;
	localparam int EDGE_T16_BIT  = 4;
	localparam int FLAG_T16_BIT  = 2;

	// Clock mode values and the reset value of the other registers
	localparam logic [7:0] CLOCK_MODE_RESET      = 8'he6;
	localparam logic [7:0] CLOCK_MODE_SLOW_CAL   = 8'he4;
	localparam logic [7:0] CLOCK_MODE_FAST2_CAL  = 8'h34;
	localparam logic [7:0] CLOCK_MODE_FAST4_CAL  = 8'h14;
	localparam logic [7:0] CLOCK_MODE_BOOT_FAST64 = 8'hd6;
	localparam logic [7:0] REG_RESET             = 8'h00;

	// Crystal range the edge sampler is sized for
	localparam int CRYSTAL_MIN_KHZ = 32;
	localparam int CRYSTAL_MAX_KHZ = 4000;
	localparam int CLK_SYS_KHZ     = 50000;

	typedef enum logic [1:0] {
		CAL_DISABLED = 2'b00,
		CAL_SLOW     = 2'b01,
		CAL_FAST2    = 2'b10,
		CAL_FAST4    = 2'b11
	} cal_option_type;

	typedef enum logic [1:0] {
		SRC_FAST = 2'b00,
		SRC_SLOW = 2'b01,
		SRC_XTAL = 2'b10
	} core_src_type;

	typedef enum logic [2:0] {
		T16_STOP   = 3'b000,
		T16_CORE   = 3'b001,
		T16_UNUSED = 3'b010,
		T16_PA4    = 3'b011,
		T16_FAST   = 3'b100,
		T16_XTAL   = 3'b101,
		T16_SLOW   = 3'b110,
		T16_PA0    = 3'b111
	} t16_src_type;

	typedef enum logic [1:0] {
		BOOT_WAIT1 = 2'b00,
		BOOT_WAIT2 = 2'b01,
		BOOT_APPLY = 2'b10,
		BOOT_RUN   = 2'b11
	} boot_state_type;

	// Pin index in the edge-sampler array
	localparam int PIN_FAST  = 0;
	localparam int PIN_SLOW  = 1;
	localparam int PIN_XTAL  = 2;
	localparam int PIN_PA0   = 3;
	localparam int PIN_PA4   = 4;
	localparam int PIN_COUNT = 5;

endpackage : clk_timer_pkg

// ### rtl/pin_edge_sync.sv
// Two-flop synchroniser with rising-edge pulse for one outside level.
// Assumes the input toggles slower than half the system clock.
`timescale 1ns/1ns
module pin_edge_sync (
	input  wire logic clk_sys,
	input  wire logic resetn,
	input  wire logic pin,
	output logic      rise_q
);

	logic meta_q;
	logic sync_q;
	logic last_q;
	wire  rise_d = sync_q & ~last_q;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			last_q <= 1'b0;
			rise_q <= 1'b0;
		end else begin
			meta_q <= pin;
			sync_q <= meta_q;
			last_q <= sync_q;
			rise_q <= rise_d;
		end
	end

endmodule : pin_edge_sync

// ### verification/core_clock_select_and_sixteen_bit_timer_bench.sv
// Self-checking bench for the clock-control and 16-bit timer block.
// Assumes registered read data one cycle after the read strobe and slow pin edges.
`timescale 1ns/1ns
module core_clock_select_and_sixteen_bit_timer_bench;
	logic        clk_sys   = 1'b0;
	logic        resetn    = 1'b0;
	logic [5:0]  reg_addr  = 6'h00;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_write = 1'b0;
	logic        reg_read  = 1'b0;
	logic        st        = 1'b0;
	logic [15:0] st_data   = 16'h0000;
	logic        ld        = 1'b0;
	logic [4:0]  pins      = 5'h00;
	logic [1:0]  cal       = 2'h1;
	logic        strap     = 1'b1;
	logic [7:0]  reg_rdata;
	logic [15:0] cnt_out;
	logic        fast_en, slow_en, xtal_en, wdog, l5, treq;
	logic [1:0]  drv, src;
	logic [2:0]  div;
	int          fail_count = 0;
	int          checks_done = 0;
	int          cycles = 0;

	core_clock_select_and_sixteen_bit_timer core_clock_select_and_sixteen_bit_timer_i (
		.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.counter_store_insn(st), .counter_store_data(st_data), .counter_load_insn(ld),
		.counter_load_data(cnt_out), .internal_fast_rc(pins[clk_timer_pkg::PIN_FAST]),
		.internal_slow_rc(pins[clk_timer_pkg::PIN_SLOW]),
		.crystal_oscillator(pins[clk_timer_pkg::PIN_XTAL]),
		.port_a_line0(pins[clk_timer_pkg::PIN_PA0]), .port_a_line4(pins[clk_timer_pkg::PIN_PA4]),
		.calibration_directive(cal), .boot_fast_strap(strap), .fast_rc_enable(fast_en),
		.slow_rc_enable(slow_en), .crystal_enable(xtal_en), .crystal_drive(drv),
		.core_clock_source(src), .core_clock_div_log2(div), .watchdog_enable(wdog),
		.port_a_line5_input(l5), .timer_request(treq)
	);

	initial begin
		forever #10 clk_sys = ~clk_sys;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic end_sim;
		$display("checks %0d, mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_sim

	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			fail_count++;
			end_sim();
		end
	end

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			fail_count++;
		end
	endtask : check

	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk_sys);
		reg_write <= 1'b0;
		#1;
	endtask : wr

	task automatic rd(input logic [5:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk_sys);
		reg_read <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd

	task automatic store(input logic [15:0] v);
		@(posedge clk_sys);
		st      <= 1'b1;
		st_data <= v;
		@(posedge clk_sys);
		st <= 1'b0;
		#1;
	endtask : store

	task automatic load;
		@(posedge clk_sys);
		ld <= 1'b1;
		@(posedge clk_sys);
		ld <= 1'b0;
		#1;
	endtask : load

	task automatic tick(input int p, input int n);
		repeat (n) begin
			@(posedge clk_sys);
			pins[p] <= 1'b1;
			repeat (4) @(posedge clk_sys);
			pins[p] <= 1'b0;
			repeat (3) @(posedge clk_sys);
		end
		repeat (6) @(posedge clk_sys);
		#1;
	endtask : tick

	function automatic logic [1:0] exp_src(input logic [7:0] m);
		case (m[7:5])
			3'b111:  return clk_timer_pkg::SRC_SLOW;
			3'b101:  return clk_timer_pkg::SRC_XTAL;
			default: return clk_timer_pkg::SRC_FAST;
		endcase
	endfunction : exp_src

	function automatic logic [2:0] exp_div(input logic [7:0] m);
		case ({m[7:5], m[3]})
			4'b0010: return 3'h1;
			4'b0000: return 3'h2;
			4'b0011: return 3'h3;
			4'b0001: return 3'h4;
			4'b0111: return 3'h5;
			default: return 3'h6;
		endcase
	endfunction : exp_div

	function automatic int pin_of(input int code);
		case (code)
			1:       return clk_timer_pkg::PIN_FAST;
			3:       return clk_timer_pkg::PIN_PA4;
			4:       return clk_timer_pkg::PIN_FAST;
			5:       return clk_timer_pkg::PIN_XTAL;
			6:       return clk_timer_pkg::PIN_SLOW;
			default: return clk_timer_pkg::PIN_PA0;
		endcase
	endfunction : pin_of

	task automatic mode_chk(input logic [7:0] m);
		check(src, exp_src(m));
		if (exp_src(m) == clk_timer_pkg::SRC_FAST) check(div, exp_div(m));
		check({fast_en, slow_en, wdog, l5}, {m[4], m[2], m[1], ~m[0]});
	endtask : mode_chk

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [10:0] boots[5] = '{{2'd0, 1'b1, 8'he6}, {2'd0, 1'b0, 8'hd6},
			{2'd2, 1'b1, 8'h34}, {2'd3, 1'b1, 8'h14}, {2'd1, 1'b1, 8'he4}};
		logic [7:0]  modes[7] = '{8'h34, 8'hb0, 8'h14, 8'hf4, 8'ha6, 8'hb4, 8'h34};
		int          srcs[8]  = '{0, 2, 3, 4, 5, 6, 7, 1};
		logic [7:0]  r8, m;
		logic [15:0] r;
		int          pre, n;
		void'($urandom(42));
		// Boot values for every calibration option
		foreach (boots[i]) begin
			@(posedge clk_sys);
			cal   <= boots[i][10:9];
			strap <= boots[i][8];
			resetn <= 1'b0;
			repeat (16) @(posedge clk_sys);
			resetn <= 1'b1;
			repeat (8) @(posedge clk_sys);
			rd(clk_timer_pkg::CLOCK_MODE_OFFSET, r8);
			check(r8, boots[i][7:0]);
			mode_chk(boots[i][7:0]);
		end
		// Crystal control, disabled first, ending enabled at high drive
		for (int i = 0; i < 4; i++) begin
			m = {i != 0, 2'(i), 5'($urandom)};
			wr(clk_timer_pkg::CRYSTAL_CTRL_OFFSET, m);
			@(posedge clk_sys);
			#1;
			check({xtal_en, drv}, m[7:5]);
			rd(clk_timer_pkg::CRYSTAL_CTRL_OFFSET, r8);
			check(r8, m);
		end
		wr(6'h3f, 8'hff);
		rd(6'h3f, r8);
		check(r8, 8'h00);
		// Crystal counted by the timer before it is ever chosen as core clock
		wr(clk_timer_pkg::SIXTEEN_BIT_TIMER_MODE_OFFSET, 8'ha0);
		store(16'h0000);
		tick(clk_timer_pkg::PIN_XTAL, 2);
		load;
		check(cnt_out, 16'h0002);
		// Clock switching, never dropping the running oscillator in the same write
		foreach (modes[i]) begin
			wr(clk_timer_pkg::CLOCK_MODE_OFFSET, modes[i]);
			mode_chk(modes[i]);
			rd(clk_timer_pkg::CLOCK_MODE_OFFSET, r8);
			check(r8, modes[i]);
		end
		r = 16'($urandom);
		store(r);
		load;
		check(cnt_out, r);
		// Every timer source with a random prescaler, fixed at /4 for fast RC
		foreach (srcs[i]) begin
			pre = (i == 3) ? 1 : $urandom_range(3, 0);
			m = {3'(srcs[i]), 2'(pre), 3'h0};
			wr(clk_timer_pkg::SIXTEEN_BIT_TIMER_MODE_OFFSET, m);
			rd(clk_timer_pkg::SIXTEEN_BIT_TIMER_MODE_OFFSET, r8);
			check(r8, m);
			r = (i == 2) ? 16'hffff : 16'($urandom);
			store(r);
			tick(pin_of(srcs[i]), 2 << (2 * pre));
			load;
			// Core clock is fast RC divided by two after the last mode write
			check(cnt_out, r + ((srcs[i] == 0 || srcs[i] == 2) ? 16'h0 :
				(srcs[i] == 1) ? 16'h1 : 16'h2));
		end
		// Request bit selection on both edges, with the opposite edge ignored
		for (int e = 0; e < 2; e++) begin
			wr(clk_timer_pkg::EDGE_SELECT_OFFSET, e ? 8'h10 : 8'h00);
			for (int s = 0; s < 8; s++) begin
				for (int k = 0; k < 2; k++) begin
					n = 8 + s;
					wr(clk_timer_pkg::SIXTEEN_BIT_TIMER_MODE_OFFSET, {3'h7, 2'h0, 3'(s)});
					r = ((e ^ k) != 0) ? 16'((1 << (n + 1)) - 1) : 16'((1 << n) - 1);
					store(r);
					repeat (4) @(posedge clk_sys);
					wr(clk_timer_pkg::IRQ_FLAGS_OFFSET, 8'h00);
					check(treq, 1'b0);
					tick(clk_timer_pkg::PIN_PA0, 1);
					check(treq, k == 0);
					rd(clk_timer_pkg::IRQ_FLAGS_OFFSET, r8);
					check(r8[2], k == 0);
				end
			end
		end
		// Crystal fully off before any power-down
		wr(clk_timer_pkg::CRYSTAL_CTRL_OFFSET, 8'h00);
		@(posedge clk_sys);
		#1;
		check(xtal_en, 1'b0);
		end_sim();
	end
endmodule : core_clock_select_and_sixteen_bit_timer_bench
